/* logic/nco_phase_regs.sv */
// What this block does
// - Accumulator is low, high and upper byte registers, one value.
// - Three bytes reserve 24 bits; only 20 are real accumulator storage.
// - Upper byte bits 3..0 are accumulator bits 19..16, read/write.
// - Upper byte bits 7..4 ignore writes and read as zero.
// - Accumulator runs on source clock; byte reads are not an atomic snapshot.
// - Increment appears as three byte registers; high byte holds bits 15..8.
// - Shadow loads on first source falling edge after a low-byte write.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "nco_cfg.svh"

module nco_phase_regs
   import nco_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_src_clk,
   input wire logic i_enable,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic [`NCO_WORD_W-1:0] o_phase,
   output logic o_overflow
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Replaces one byte lane of a phase word; the upper lane keeps only
   // its low nibble because the word is 20 bits wide.
   function automatic nco_word_t put_byte(input nco_word_t w,
                                          input nco_lane_t lane,
                                          input nco_byte_t b);
      nco_word_t r;
      r = w;
      case (lane)
         `NCO_LANE_LOW: r[7:0] = b;
         `NCO_LANE_HIGH: r[15:8] = b;
         `NCO_LANE_UPPER: r[19:16] = b[3:0];
         default: r = w;
      endcase
      return r;
   endfunction

   // Reads one byte lane; bits above bit 19 always read as zero.
   function automatic nco_byte_t get_byte(input nco_word_t w,
                                          input nco_lane_t lane);
      nco_byte_t r;
      r = `NCO_BYTE_ZERO;
      case (lane)
         `NCO_LANE_LOW: r = w[7:0];
         `NCO_LANE_HIGH: r = w[15:8];
         `NCO_LANE_UPPER: r = {`NCO_NIB_ZERO, w[19:16]};
         default: r = `NCO_BYTE_ZERO;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Source clock synchroniser
   // ---------------------------------------------------------------

   logic sync1_q, sync2_q, sync3_q, level_q;
   logic sync1_d, sync2_d, sync3_d, level_d;
   logic src_fall;

   // The source clock is a pin in its own domain. A new level counts
   // only when the second and third stages agree, which filters a
   // single-cycle glitch at the cost of one extra cycle of latency.
   always_comb
   begin
      sync1_d = i_src_clk;
      sync2_d = sync1_q;
      sync3_d = sync2_q;
      level_d = level_q;
      if (sync2_q == sync3_q)
      begin
         level_d = sync3_q;
      end
   end

   // A falling edge is an agreed change from high to low.
   assign src_fall = level_q && (sync2_q == sync3_q) && !sync3_q;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
         level_q <= level_d;
      end
   end

   // ---------------------------------------------------------------
   // Phase state and register file
   // ---------------------------------------------------------------

   nco_word_t acc_q, acc_d;
   nco_word_t inc_q, inc_d;
   nco_word_t shadow_q, shadow_d;
   logic pend_q, pend_d;
   logic ovf_q, ovf_d;
   logic [7:0] rdata_q, rdata_d;
   logic [`NCO_WORD_W:0] sum;
   logic wr_acc;

   // Sum carries one extra bit so the overflow can be seen.
   assign sum = {1'b0, acc_q} + {1'b0, shadow_q};
   assign wr_acc = i_wr && (i_addr == `NCO_OFS_ACCL ||
                            i_addr == `NCO_OFS_ACCH ||
                            i_addr == `NCO_OFS_ACCU);

   // A software write to the accumulator wins over a step in the same
   // cycle; the result while running is undefined anyway.
   always_comb
   begin
      acc_d = acc_q;
      inc_d = inc_q;
      shadow_d = shadow_q;
      pend_d = pend_q;
      ovf_d = 1'b0;
      if (src_fall && i_enable)
      begin
         acc_d = sum[`NCO_WORD_W-1:0];
         ovf_d = sum[`NCO_WORD_W];
      end
      if (src_fall && pend_q)
      begin
         shadow_d = inc_q;
         pend_d = 1'b0;
      end
      if (i_wr)
      begin
         case (i_addr)
            `NCO_OFS_ACCL:
               acc_d = put_byte(acc_q, `NCO_LANE_LOW, i_wdata);
            `NCO_OFS_ACCH: acc_d = put_byte(acc_q, `NCO_LANE_HIGH, i_wdata);
            `NCO_OFS_ACCU:
               acc_d = put_byte(acc_q, `NCO_LANE_UPPER, i_wdata);
            `NCO_OFS_INCL:
            begin
               inc_d = put_byte(inc_q, `NCO_LANE_LOW, i_wdata);
               pend_d = 1'b1;
            end
            `NCO_OFS_INCH:
               inc_d = put_byte(inc_q, `NCO_LANE_HIGH, i_wdata);
            `NCO_OFS_INCU:
               inc_d = put_byte(inc_q, `NCO_LANE_UPPER, i_wdata);
            default: inc_d = inc_q;
         endcase
      end
      if (wr_acc)
      begin
         ovf_d = 1'b0;
      end
   end

   // Reads return data only in the cycle after the strobe; the three
   // bytes are sampled at different times while the accumulator runs.
   always_comb
   begin
      rdata_d = `NCO_BYTE_ZERO;
      if (i_rd)
      begin
         case (i_addr)
            `NCO_OFS_ACCL: rdata_d = get_byte(acc_q, `NCO_LANE_LOW);
            `NCO_OFS_ACCH: rdata_d = get_byte(acc_q, `NCO_LANE_HIGH);
            `NCO_OFS_ACCU: rdata_d = get_byte(acc_q, `NCO_LANE_UPPER);
            `NCO_OFS_INCL: rdata_d = get_byte(inc_q, `NCO_LANE_LOW);
            `NCO_OFS_INCH: rdata_d = get_byte(inc_q, `NCO_LANE_HIGH);
            `NCO_OFS_INCU: rdata_d = get_byte(inc_q, `NCO_LANE_UPPER);
            default: rdata_d = `NCO_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         acc_q <= `NCO_ACC_RST;
         inc_q <= `NCO_INC_RST;
         shadow_q <= `NCO_INC_RST;
         pend_q <= 1'b0;
         ovf_q <= 1'b0;
         rdata_q <= `NCO_BYTE_ZERO;
      end
      else
      begin
         acc_q <= acc_d;
         inc_q <= inc_d;
         shadow_q <= shadow_d;
         pend_q <= pend_d;
         ovf_q <= ovf_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs come straight from flip-flops.
   assign o_rdata = rdata_q;
   assign o_phase = acc_q;
   assign o_overflow = ovf_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   AST_RD_ACCL: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_rd && i_addr == `NCO_OFS_ACCL |=> o_rdata == $past(acc_q[7:0]))
      else $error("Low accumulator byte read wrong.");

   AST_RD_ACCU_TOP: assert property (@(posedge i_clk)
      disable iff (!i_nrst)
      i_rd && i_addr == `NCO_OFS_ACCU |=> o_rdata[7:4] == `NCO_NIB_ZERO &&
      o_rdata[3:0] == $past(acc_q[19:16]))
      else $error("Upper accumulator byte read wrong.");

   AST_WR_ACCU: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_wr && i_addr == `NCO_OFS_ACCU |=>
      o_phase[19:16] == $past(i_wdata[3:0]) &&
      o_phase[15:0] == $past(acc_q[15:0]))
      else $error("Upper accumulator byte write wrong.");

   AST_ACC_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !src_fall && !wr_acc |=> $stable(o_phase))
      else $error("Accumulator moved without a source edge.");

   AST_ACC_STEP: assert property (@(posedge i_clk) disable iff (!i_nrst)
      src_fall && i_enable && !wr_acc |=>
      o_phase == nco_word_t'($past(acc_q) + $past(shadow_q)) &&
      o_overflow == ($past(acc_q) > ~$past(shadow_q)))
      else $error("Accumulator step or overflow wrong.");

   AST_WR_INCH: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_wr && i_addr == `NCO_OFS_INCH |=>
      inc_q[15:8] == $past(i_wdata) && inc_q[7:0] == $past(inc_q[7:0]))
      else $error("High increment byte write wrong.");

   AST_SHADOW_LOAD: assert property (@(posedge i_clk)
      disable iff (!i_nrst)
      src_fall && pend_q |=> shadow_q == $past(inc_q))
      else $error("Shadow did not load on source edge.");

   AST_SHADOW_HOLD: assert property (@(posedge i_clk)
      disable iff (!i_nrst)
      !(src_fall && pend_q) |=> $stable(shadow_q))
      else $error("Shadow changed without a pending load.");

   AST_PEND_SET: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_wr && i_addr == `NCO_OFS_INCL |=> pend_q)
      else $error("Low increment write lost its load request.");

endmodule

/* logic/nco_cfg.svh */
`ifndef NCO_CFG_SVH
`define NCO_CFG_SVH

// Register byte offsets on the plain register port.
`define NCO_OFS_ACCL 3'h0
`define NCO_OFS_ACCH 3'h1
`define NCO_OFS_ACCU 3'h2
`define NCO_OFS_INCL 3'h3
`define NCO_OFS_INCH 3'h4
`define NCO_OFS_INCU 3'h5

// Widths of the implemented phase word and of its reserved space.
`define NCO_WORD_W 20
`define NCO_SPACE_W 24

// Byte lane selectors inside a phase word.
`define NCO_LANE_LOW 2'h0
`define NCO_LANE_HIGH 2'h1
`define NCO_LANE_UPPER 2'h2

// Reset values.
`define NCO_ACC_RST 20'h00000
`define NCO_INC_RST 20'h00001
`define NCO_BYTE_ZERO 8'h00
`define NCO_NIB_ZERO 4'h0

`endif

/* logic/nco_pkg.sv */
`include "nco_cfg.svh"

package nco_pkg;

   // A phase word: accumulator, increment or shadow.
   typedef logic [`NCO_WORD_W-1:0] nco_word_t;

   // One software-visible byte register.
   typedef logic [7:0] nco_byte_t;

   // Register address on the plain register port.
   typedef logic [2:0] nco_addr_t;

   // Byte lane inside a phase word.
   typedef logic [1:0] nco_lane_t;

endpackage

/* testbench/nco_phase_accumulator_regs_tb.sv */
`timescale 1ns/1ps
`include "nco_cfg.svh"

module nco_phase_accumulator_regs_tb
   import nco_pkg::*;
();
   // ---------------------------------------------------------------
   // Stimulus signals and the bench's own copy of the registers.
   // ---------------------------------------------------------------
   logic i_clk = 1'h0;
   logic i_nrst = 1'h0;
   logic i_src_clk = 1'h0;
   logic i_enable = 1'h0;
   logic i_wr = 1'h0;
   logic i_rd = 1'h0;
   nco_addr_t i_addr = 3'h0;
   nco_byte_t i_wdata = 8'h00;
   logic [7:0] o_rdata;
   nco_word_t o_phase;
   logic o_overflow;
   int err_total = 0;
   int num_checks = 0;
   int seed = 14;
   nco_word_t acc_m = `NCO_ACC_RST;
   nco_word_t inc_m = `NCO_INC_RST;
   nco_word_t shd_m = `NCO_INC_RST;
   logic pend_m = 1'h0;
   logic ovf_seen;

   // The 25 MHz system clock.
   always #20 i_clk = ~i_clk;

   nco_phase_regs DUT (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_src_clk(i_src_clk), .i_enable(i_enable), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_phase(o_phase), .o_overflow(o_overflow));

   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------
   // Ends the run; a hang cut short also lands here.
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input nco_word_t e, input nco_word_t g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Expected read data; unmapped places and spare nibbles read zero.
   function automatic nco_byte_t exp_byte(input nco_addr_t a);
      case (a)
         `NCO_OFS_ACCL: return acc_m[7:0];
         `NCO_OFS_ACCH: return acc_m[15:8];
         `NCO_OFS_ACCU: return {4'h0, acc_m[19:16]};
         `NCO_OFS_INCL: return inc_m[7:0];
         `NCO_OFS_INCH: return inc_m[15:8];
         `NCO_OFS_INCU: return {4'h0, inc_m[19:16]};
         default: return 8'h00;
      endcase
   endfunction

   // One-cycle write; the model follows what the register should keep.
   task automatic wr(input nco_addr_t a, input nco_byte_t d);
      @(posedge i_clk);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'h0;
      case (a)
         `NCO_OFS_ACCL: acc_m[7:0] = d;
         `NCO_OFS_ACCH: acc_m[15:8] = d;
         `NCO_OFS_ACCU: acc_m[19:16] = d[3:0];
         `NCO_OFS_INCL: inc_m[7:0] = d;
         `NCO_OFS_INCH: inc_m[15:8] = d;
         `NCO_OFS_INCU: inc_m[19:16] = d[3:0];
         default: ;
      endcase
      if (a == `NCO_OFS_INCL)
         pend_m = 1'h1;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input nco_addr_t a);
      @(posedge i_clk);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 chk("read data", {12'h000, exp_byte(a)}, {12'h000, o_rdata});
   endtask

   // One source clock period; the falling edge steps and loads the
   // shadow, the step still using the shadow from before the load.
   task automatic step(input logic en);
      logic [20:0] s;
      s = {1'h0, acc_m} + {1'h0, shd_m};
      @(posedge i_clk);
      i_enable <= en;
      i_src_clk <= 1'h1;
      repeat (3) @(posedge i_clk);
      i_src_clk <= 1'h0;
      ovf_seen = 1'h0;
      repeat (8)
      begin
         @(posedge i_clk);
         #1 ovf_seen = ovf_seen | o_overflow;
      end
      i_enable <= 1'h0;
      if (en)
         acc_m = s[19:0];
      if (pend_m)
         shd_m = inc_m;
      pend_m = 1'h0;
      chk("overflow", {19'h0, en & s[20]}, {19'h0, ovf_seen});
      chk("phase", acc_m, o_phase);
   endtask

   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'h1;
      for (int a = 0; a < 8; a++)
         rd(3'(a));
      // Accumulator written only while stopped; spare nibble set high.
      wr(`NCO_OFS_ACCL, 8'($random(seed)));
      wr(`NCO_OFS_ACCH, 8'($random(seed)));
      wr(`NCO_OFS_ACCU, 8'hFF);
      #1 chk("phase", acc_m, o_phase);
      for (int a = 0; a < 3; a++)
         rd(3'(a));
      // Random increments; the low byte goes last, as software must.
      repeat (12)
      begin
         wr(`NCO_OFS_INCU, 8'($random(seed)));
         wr(`NCO_OFS_INCH, 8'($random(seed)));
         step(1'($random(seed)));
         wr(`NCO_OFS_INCL, 8'($random(seed)));
         step(1'h1);
         step(1'h1);
         for (int a = 0; a < 6; a++)
            rd(3'(a));
      end
      // Wrap from the top of the 20-bit range to zero.
      wr(`NCO_OFS_INCU, 8'h00);
      wr(`NCO_OFS_INCH, 8'h00);
      wr(`NCO_OFS_INCL, 8'h01);
      step(1'h0);
      wr(`NCO_OFS_ACCL, 8'hFF);
      wr(`NCO_OFS_ACCH, 8'hFF);
      wr(`NCO_OFS_ACCU, 8'hFF);
      step(1'h1);
      rd(`NCO_OFS_ACCU);
      print_verdict;
   end

   // A hung run counts as a mismatch.
   initial
   begin
      #4000000;
      err_total++;
      print_verdict;
   end
endmodule
